// *** design/mixer_consts.svh ***
// Named constants for the complex signal mixer.
// Assumes inclusion by bare name from the design file.
`ifndef MIXER_CONSTS_SVH
`define MIXER_CONSTS_SVH

// ========================================
// Register offsets (byte addresses)
`define OFS_FREQ_WORD_PAIR0 8'h00
`define OFS_FREQ_WORD_PAIR1 8'h04
`define OFS_PHASE_OFS       8'h08
`define OFS_DATAPATH_CTRL   8'h0C
`define OFS_SYNC_SELECT     8'h10
`define OFS_ACC_PAIR0       8'h14
`define OFS_ACC_PAIR1       8'h18

// ========================================
// Field positions
`define CTRL_CMIX_LSB       0
`define CTRL_CMIX_MSB       3
`define CTRL_GAIN_BIT       4
`define CTRL_FULL_BIT       5
`define CMIX_FS8_BIT        3
`define CMIX_PFS4_BIT       2
`define CMIX_FS2_BIT        1
`define CMIX_MFS4_BIT       0
`define PHASE_OFS1_LSB      16

// ========================================
// Reset values
`define RST_FREQ_WORD       32'h0000_0000
`define RST_PHASE_OFS       16'h0000
`define RST_CMIX            4'h0
`define RST_GAIN            1'h0
`define RST_FULL            1'h0
`define RST_SYNC_SEL        4'h0

// ========================================
// Datapath constants
`define LUT_QUARTER         6'h10
`define FS8_STEP_SHIFT      3
`define MUL_SHIFT_UNITY     15
`define MUL_SHIFT_HALF      16
`define FIFO_DEPTH_DEF      8

`endif

// *** design/mixer_pkg.sv ***
// Types shared by the complex signal mixer files.
// Assumes nothing of its surroundings.
package mixer_pkg;

   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } iq_pair_t;

   typedef struct packed {
      iq_pair_t cd;
      iq_pair_t ab;
   } mix_sample_t;

   typedef struct packed {
      logic [3:0] cmix;
      logic       gain;
      logic       full_mixer;
   } mix_ctrl_t;

endpackage

// *** design/complex_signal_mixer.sv ***
// Two-pair complex mixer with oscillators, coarse mixer and input FIFO.
// Assumes one 100 MHz sample clock, samples on a valid/ready stream
// and sync sources arriving asynchronously on pins.
// What this block does
// - Each oscillator adds its 32-bit frequency word every clock.
// - Accumulator wraps modulo two to the thirty-two.
// - Selected sync source clears both accumulators; mixing time restarts.
// - Sixteen-bit phase offset per pair adds to the oscillator phase.
// - Each pair has its own oscillator, frequency word and phase offset.
// - Full mixing: I=I*cos-Q*sin, Q=I*sin+Q*cos.
// - Gain bit zero halves multiplier output; gain bit one leaves it unscaled.
// - Coarse fs/2 negates every second sample on I and Q.
// - Coarse +fs/4 gives I:{I1,-Q2,-I3,Q4}, Q:{Q1,I2,-Q3,-I4}.
// - Coarse -fs/4 gives I:{I1,Q2,-I3,-Q4}, Q:{Q1,-I2,-Q3,I4}.
// - fs/2 and fs/4 modes bypass the multiplier, so no gain applies.
// - fs/8 uses the multiplier with fixed fs/8 terms and gain option.
// - Coarse field bits: 3 fs/8, 2 +fs/4, 1 fs/2, 0 -fs/4.
// - fs/8 combines with other stages to give the net shifts.
// - Only bypass or fs/2 keep I and Q separated.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "mixer_consts.svh"

// ========================================
// Sample FIFO
module sample_fifo
   import mixer_pkg::*;
#(
   parameter int WIDTH = 64,
   parameter int DEPTH = `FIFO_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   // Fill side
   input  wire logic             i_wr_valid,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output      logic             o_wr_ready,
   // Drain side
   output      logic             o_rd_valid,
   output      logic [WIDTH-1:0] o_rd_data,
   input  wire logic             i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign o_wr_ready = (count_reg != (AW+1)'(DEPTH));
   assign o_rd_valid = (count_reg != '0);
   assign push       = i_wr_valid && o_wr_ready;
   assign pop        = o_rd_valid && i_rd_ready;
   assign o_rd_data  = mem[rd_ptr_reg];

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_wr_data;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                                                        : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                                                        : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_full_stall: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      (count_reg == (AW+1)'(DEPTH)) |=> $stable(wr_ptr_reg))
      else $error("FIFO write pointer moved while full");
endmodule

// ========================================
// Mixer top
module complex_signal_mixer
   import mixer_pkg::*;
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF,
   parameter int NUM_SYNC   = 16
) (
   // Clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_rst_n,
   // Register port
   input  wire logic [7:0]          i_addr,
   input  wire logic [31:0]         i_wr_data,
   input  wire logic                i_wr_en,
   input  wire logic                i_rd_en,
   output      logic [31:0]         o_rd_data,
   // Sync sources from pins
   input  wire logic [NUM_SYNC-1:0] i_sync_src,
   // Input sample stream
   input  wire logic                i_in_valid,
   input  wire mix_sample_t         i_in_data,
   output      logic                o_in_ready,
   // Output sample stream
   output      logic                o_out_valid,
   output      mix_sample_t         o_out_data,
   input  wire logic                i_out_ready
);
   // ========================================
   // Helper functions
   function automatic logic signed [15:0] quarter_sin(input logic [4:0] k);
      case (k)
         5'h00: quarter_sin = 16'sh0000;
         5'h01: quarter_sin = 16'sh0C8C;
         5'h02: quarter_sin = 16'sh18F9;
         5'h03: quarter_sin = 16'sh2528;
         5'h04: quarter_sin = 16'sh30FB;
         5'h05: quarter_sin = 16'sh3C56;
         5'h06: quarter_sin = 16'sh471C;
         5'h07: quarter_sin = 16'sh5133;
         5'h08: quarter_sin = 16'sh5A82;
         5'h09: quarter_sin = 16'sh62F1;
         5'h0A: quarter_sin = 16'sh6A6D;
         5'h0B: quarter_sin = 16'sh70E2;
         5'h0C: quarter_sin = 16'sh7641;
         5'h0D: quarter_sin = 16'sh7A7C;
         5'h0E: quarter_sin = 16'sh7D89;
         5'h0F: quarter_sin = 16'sh7F61;
         default: quarter_sin = 16'sh7FFF;
      endcase
   endfunction

   // Sine of 2*pi*p/64
   function automatic logic signed [15:0] sin_lut(input logic [5:0] p);
      logic [4:0] fwd;
      logic [4:0] rev;
      fwd = {1'b0, p[3:0]};
      rev = 5'h10 - fwd;
      case (p[5:4])
         2'h0:    sin_lut = quarter_sin(fwd);
         2'h1:    sin_lut = quarter_sin(rev);
         2'h2:    sin_lut = -quarter_sin(fwd);
         default: sin_lut = -quarter_sin(rev);
      endcase
   endfunction

   function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
      if (v > 34'sh0_0000_7FFF) begin
         sat16 = 16'sh7FFF;
      end else if (v < -34'sh0_0000_8000) begin
         sat16 = 16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction

   // ========================================
   // Registers
   logic [31:0]      freq_word_reg [2];
   logic [15:0]      phase_ofs_reg [2];
   mix_ctrl_t        datapath_ctrl_reg;
   logic [3:0]       sync_select_reg;
   logic [31:0]      acc_reg [2];
   logic [31:0]      rd_data_next;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         freq_word_reg[0]  <= `RST_FREQ_WORD;
         freq_word_reg[1]  <= `RST_FREQ_WORD;
         phase_ofs_reg[0]  <= `RST_PHASE_OFS;
         phase_ofs_reg[1]  <= `RST_PHASE_OFS;
         datapath_ctrl_reg <= '{cmix: `RST_CMIX, gain: `RST_GAIN,
                                full_mixer: `RST_FULL};
         sync_select_reg   <= `RST_SYNC_SEL;
      end else if (i_wr_en) begin
         case (i_addr)
            `OFS_FREQ_WORD_PAIR0: freq_word_reg[0] <= i_wr_data;
            `OFS_FREQ_WORD_PAIR1: freq_word_reg[1] <= i_wr_data;
            `OFS_PHASE_OFS: begin
               phase_ofs_reg[0] <= i_wr_data[15:0];
               phase_ofs_reg[1] <= i_wr_data[31:`PHASE_OFS1_LSB];
            end
            `OFS_DATAPATH_CTRL: begin
               datapath_ctrl_reg.cmix <=
                  i_wr_data[`CTRL_CMIX_MSB:`CTRL_CMIX_LSB];
               datapath_ctrl_reg.gain       <= i_wr_data[`CTRL_GAIN_BIT];
               datapath_ctrl_reg.full_mixer <= i_wr_data[`CTRL_FULL_BIT];
            end
            `OFS_SYNC_SELECT: sync_select_reg <= i_wr_data[3:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_data_next = '0;
      case (i_addr)
         `OFS_FREQ_WORD_PAIR0: rd_data_next = freq_word_reg[0];
         `OFS_FREQ_WORD_PAIR1: rd_data_next = freq_word_reg[1];
         `OFS_PHASE_OFS:       rd_data_next = {phase_ofs_reg[1],
                                               phase_ofs_reg[0]};
         `OFS_DATAPATH_CTRL:   rd_data_next = {26'h0,
                                  datapath_ctrl_reg.full_mixer,
                                  datapath_ctrl_reg.gain,
                                  datapath_ctrl_reg.cmix};
         `OFS_SYNC_SELECT:     rd_data_next = {28'h0, sync_select_reg};
         `OFS_ACC_PAIR0:       rd_data_next = acc_reg[0];
         `OFS_ACC_PAIR1:       rd_data_next = acc_reg[1];
         default:              rd_data_next = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_data <= '0;
      end else begin
         o_rd_data <= i_rd_en ? rd_data_next : '0;
      end
   end

   // ========================================
   // Sync source selection and edge detect
   logic [NUM_SYNC-1:0] sync_meta_reg;
   logic [NUM_SYNC-1:0] sync_sync_reg;
   logic                sync_prev_reg;
   logic                sync_sel_level;
   logic                sync_evt;

   assign sync_sel_level = sync_sync_reg[sync_select_reg];
   assign sync_evt       = sync_sel_level && !sync_prev_reg;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_meta_reg <= '0;
         sync_sync_reg <= '0;
         sync_prev_reg <= 1'b0;
      end else begin
         sync_meta_reg <= i_sync_src;
         sync_sync_reg <= sync_meta_reg;
         sync_prev_reg <= sync_sel_level;
      end
   end

   // ========================================
   // Oscillators, one per pair
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_osc
         always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               acc_reg[gp] <= '0;
            end else if (sync_evt) begin
               acc_reg[gp] <= '0;
            end else begin
               acc_reg[gp] <= acc_reg[gp] + freq_word_reg[gp];
            end
         end

         a_acc_step: assert property (@(posedge i_core_clk)
            disable iff (!i_rst_n)
            !sync_evt |=> acc_reg[gp] ==
               $past(acc_reg[gp]) + $past(freq_word_reg[gp]))
            else $error("Accumulator did not step by the frequency word");

         a_sync_clear: assert property (@(posedge i_core_clk)
            disable iff (!i_rst_n)
            sync_evt |=> acc_reg[gp] == '0)
            else $error("Sync event did not clear accumulator");
      end
   endgenerate

   // ========================================
   // Input FIFO and stream handshake
   mix_sample_t fifo_data;
   logic        fifo_valid;
   logic        fifo_ready;
   logic        fire;
   logic [2:0]  sample_cnt_reg;

   sample_fifo #(
      .WIDTH ($bits(mix_sample_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_wr_valid (i_in_valid),
      .i_wr_data  (i_in_data),
      .o_wr_ready (o_in_ready),
      .o_rd_valid (fifo_valid),
      .o_rd_data  (fifo_data),
      .i_rd_ready (fifo_ready)
   );

   assign fifo_ready = !o_out_valid || i_out_ready;
   assign fire       = fifo_valid && fifo_ready;

   // Sample position within coarse sequences, restarted by sync
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sample_cnt_reg <= '0;
      end else if (sync_evt) begin
         sample_cnt_reg <= '0;
      end else if (fire) begin
         sample_cnt_reg <= sample_cnt_reg + 1'b1;
      end
   end

   // ========================================
   // Coarse rotation and complex multiplier
   logic [1:0] quarter_rate;
   logic [1:0] rot;
   logic       use_mul;
   logic [5:0] fs8_idx;
   iq_pair_t   in_pair  [2];
   iq_pair_t   out_next [2];

   // Net quarter turns per sample from the enabled fs/2, +fs/4 and -fs/4 stages
   assign quarter_rate = {datapath_ctrl_reg.cmix[`CMIX_FS2_BIT],
                          datapath_ctrl_reg.cmix[`CMIX_PFS4_BIT]}
                       + (datapath_ctrl_reg.cmix[`CMIX_MFS4_BIT] ?
                          2'h3 : 2'h0);
   assign rot = 2'(sample_cnt_reg[1:0] * quarter_rate);
   assign use_mul = datapath_ctrl_reg.full_mixer
                  || datapath_ctrl_reg.cmix[`CMIX_FS8_BIT];
   assign fs8_idx = datapath_ctrl_reg.cmix[`CMIX_FS8_BIT] ?
                    6'({sample_cnt_reg, 3'h0}) : 6'h00;
   assign in_pair[0] = fifo_data.ab;
   assign in_pair[1] = fifo_data.cd;

   generate
      for (gp = 0; gp < 2; gp++) begin : g_mix
         logic [31:0]        phase;
         logic [5:0]         idx;
         logic signed [15:0] cos_t;
         logic signed [15:0] sin_t;
         logic signed [16:0] ri;
         logic signed [16:0] rq;
         logic signed [16:0] si;
         logic signed [16:0] sq;
         logic signed [33:0] mi;
         logic signed [33:0] mq;
         logic signed [33:0] pi_s;
         logic signed [33:0] pq_s;

         assign phase = acc_reg[gp] + {phase_ofs_reg[gp], 16'h0000};
         assign idx   = (datapath_ctrl_reg.full_mixer ?
                         phase[31:26] : 6'h00) + fs8_idx;
         assign sin_t = sin_lut(idx);
         assign cos_t = sin_lut(idx + `LUT_QUARTER);
         assign si    = 17'(in_pair[gp].i);
         assign sq    = 17'(in_pair[gp].q);

         always_comb begin
            unique case (rot)
               2'h0: begin ri = si;  rq = sq;  end
               2'h1: begin ri = -sq; rq = si;  end
               2'h2: begin ri = -si; rq = -sq; end
               2'h3: begin ri = sq;  rq = -si; end
            endcase
         end

         assign mi = 34'(ri * cos_t) - 34'(rq * sin_t);
         assign mq = 34'(ri * sin_t) + 34'(rq * cos_t);
         assign pi_s = datapath_ctrl_reg.gain ? (mi >>> `MUL_SHIFT_UNITY)
                                              : (mi >>> `MUL_SHIFT_HALF);
         assign pq_s = datapath_ctrl_reg.gain ? (mq >>> `MUL_SHIFT_UNITY)
                                              : (mq >>> `MUL_SHIFT_HALF);
         assign out_next[gp].i = use_mul ? sat16(pi_s)
                                         : sat16(34'(ri));
         assign out_next[gp].q = use_mul ? sat16(pq_s)
                                         : sat16(34'(rq));
      end
   endgenerate

   // ========================================
   // Output register
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_out_valid <= 1'b0;
         o_out_data  <= '0;
      end else begin
         if (fire) begin
            o_out_valid   <= 1'b1;
            o_out_data.ab <= out_next[0];
            o_out_data.cd <= out_next[1];
         end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
         end
      end
   end

   // ========================================
   // Checks
   a_bypass_pass: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      (fire && datapath_ctrl_reg == '0) |=> o_out_data == $past(fifo_data))
      else $error("Bypass changed the sample");

   a_fs2_negate: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      (fire && datapath_ctrl_reg == mix_ctrl_t'{4'h2, 1'b0, 1'b0}
       && sample_cnt_reg[0] && fifo_data.ab.i != 16'sh8000)
      |=> o_out_data.ab.i == -$past(fifo_data.ab.i))
      else $error("fs/2 did not negate odd sample");

   a_pfs4_swap: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      (fire && datapath_ctrl_reg == mix_ctrl_t'{4'h4, 1'b1, 1'b0}
       && sample_cnt_reg[1:0] == 2'h1)
      |=> o_out_data.ab.q == $past(fifo_data.ab.i))
      else $error("+fs/4 second sample Q is not I");

   a_mfs4_swap: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      (fire && datapath_ctrl_reg == mix_ctrl_t'{4'h1, 1'b0, 1'b0}
       && sample_cnt_reg[1:0] == 2'h1)
      |=> o_out_data.cd.i == $past(fifo_data.cd.q))
      else $error("-fs/4 second sample I is not Q");

   a_sync_count: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      sync_evt |=> sample_cnt_reg == 3'h0)
      else $error("Sync did not restart sample position");

   a_out_hold: assert property (@(posedge i_core_clk)
      disable iff (!i_rst_n)
      (o_out_valid && !i_out_ready) |=> o_out_valid && $stable(o_out_data))
      else $error("Output changed while stalled");
endmodule

// *** bench/stream_sink_model.sv ***
// Downstream correction stage model: takes mixer output, stalls at random.
// Assumes one clock shared with the mixer; hold input freezes ready low.
`timescale 1ns/100ps
module stream_sink_model (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Control from bench
   input  wire logic i_hold,
   // Stream handshake
   output      logic o_ready
);
   logic [7:0] lfsr_reg;

   // ========================================
   // Ready with pseudo-random stalls
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lfsr_reg <= 8'h5A;
         o_ready  <= 1'b0;
      end else begin
         lfsr_reg <= {lfsr_reg[6:0],
                      lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
         o_ready  <= !i_hold && (lfsr_reg[1:0] != 2'h0);
      end
   end
endmodule

// *** bench/complex_signal_mixer_tb.sv ***
// Self-checking bench for the complex signal mixer.
// Assumes the mixer package, constants header and the sink model.
`timescale 1ns/100ps
`include "mixer_consts.svh"
module complex_signal_mixer_tb
   import mixer_pkg::*;
;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n    = 1'b0;
   logic [7:0]  i_addr     = 8'h00;
   logic [31:0] i_wr_data  = 32'h0;
   logic        i_wr_en    = 1'b0;
   logic        i_rd_en    = 1'b0;
   logic [31:0] o_rd_data;
   logic [15:0] i_sync_src = 16'h0;
   logic        i_in_valid = 1'b0;
   mix_sample_t i_in_data  = '0;
   logic        o_in_ready;
   logic        o_out_valid;
   mix_sample_t o_out_data;
   logic        i_out_ready;
   logic        hold       = 1'b0;
   mix_ctrl_t   ctl        = '0;
   logic [15:0] ofs0       = 16'h0;
   logic [15:0] ofs1       = 16'h0;
   logic [31:0] rv;
   logic [31:0] a0;
   logic [3:0]  modes [8]  = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'hC, 4'hE};
   mix_sample_t exp_q [$];
   mix_sample_t exp_s;
   int          err_count  = 0;
   int          num_checks = 0;
   int          seed       = 11555;
   int          pos        = 0;

   always #5 i_core_clk = ~i_core_clk;

   complex_signal_mixer #(.FIFO_DEPTH(8), .NUM_SYNC(16)) u_dut (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_addr     (i_addr),
      .i_wr_data  (i_wr_data),
      .i_wr_en    (i_wr_en),
      .i_rd_en    (i_rd_en),
      .o_rd_data  (o_rd_data),
      .i_sync_src (i_sync_src),
      .i_in_valid (i_in_valid),
      .i_in_data  (i_in_data),
      .o_in_ready (o_in_ready),
      .o_out_valid(o_out_valid),
      .o_out_data (o_out_data),
      .i_out_ready(i_out_ready)
   );

   stream_sink_model u_sink (
      .i_core_clk(i_core_clk),
      .i_rst_n   (i_rst_n),
      .i_hold    (hold),
      .o_ready   (i_out_ready)
   );

   // ========================================
   // Checking and closing
   task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                        input string what);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t: %s seen %h exp %h", $time, what, seen,
                  exp);
      end
   endtask

   task automatic test_done;
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ========================================
   // Reference model
   function automatic logic [15:0] sat(input longint v);
      return (v > 32767) ? 16'h7FFF : (v < -32768) ? 16'h8000 : v[15:0];
   endfunction

   function automatic int trig(input int idx, input bit sine);
      real v;
      v = 6.283185307179586 * idx / 64.0;
      v = (sine ? $sin(v) : $cos(v)) * 32767.0;
      return (v < 0.0) ? -$rtoi(0.5 - v) : $rtoi(v + 0.5);
   endfunction

   function automatic iq_pair_t mix_one(input iq_pair_t x,
                                        input logic [15:0] ofs);
      longint   a, b, t;
      int       idx;
      iq_pair_t y;
      a = x.i;
      b = x.q;
      repeat ((pos * (ctl.cmix[2] + 2 * ctl.cmix[1] + 3 * ctl.cmix[0])) % 4)
      begin
         t = a;
         a = -b;
         b = t;
      end
      if (ctl.full_mixer || ctl.cmix[3]) begin
         idx = ((ctl.full_mixer ? ofs[15:10] : 0) +
                (ctl.cmix[3] ? pos * 8 : 0)) % 64;
         t = a * trig(idx, 0) - b * trig(idx, 1);
         b = a * trig(idx, 1) + b * trig(idx, 0);
         a = t >>> (ctl.gain ? 15 : 16);
         b = b >>> (ctl.gain ? 15 : 16);
      end
      y.i = sat(a);
      y.q = sat(b);
      return y;
   endfunction

   // ========================================
   // Drivers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr_en   <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_rd_en <= 1'b1;
      i_addr  <= a;
      @(posedge i_core_clk);
      i_rd_en <= 1'b0;
      @(negedge i_core_clk);
      d = o_rd_data;
   endtask

   task automatic setctl;
      wr(`OFS_DATAPATH_CTRL, {26'h0, ctl.full_mixer, ctl.gain, ctl.cmix});
   endtask

   function automatic mix_sample_t rnd();
      mix_sample_t d;
      d = {$random(seed), $random(seed)};
      if (d[1:0] == 2'h0) d.ab = 32'h8000_8000;
      if (d[3:2] == 2'h0) d.cd = 32'h7FFF_8000;
      return d;
   endfunction

   // Called just after a rising edge; returns at the taking edge
   task automatic push(input mix_sample_t d);
      mix_sample_t e;
      e.ab = mix_one(d.ab, ofs0);
      e.cd = mix_one(d.cd, ofs1);
      exp_q.push_back(e);
      pos = (pos + 1) % 8;
      i_in_valid <= 1'b1;
      i_in_data  <= d;
      @(negedge i_core_clk);
      while (o_in_ready !== 1'b1) @(negedge i_core_clk);
      @(posedge i_core_clk);
   endtask

   task automatic burst(input int cnt);
      @(posedge i_core_clk);
      repeat (cnt) push(rnd());
      i_in_valid <= 1'b0;
      while (exp_q.size() > 0) @(posedge i_core_clk);
   endtask

   always @(negedge i_core_clk) begin
      if (i_rst_n && o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
         exp_s = 'x;
         if (exp_q.size() > 0) begin
            exp_s = exp_q.pop_front();
         end
         check(o_out_data.ab, exp_s.ab, "ab");
         check(o_out_data.cd, exp_s.cd, "cd");
      end
   end

   // ========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      for (int a = 0; a <= 8'h1C; a += 4) begin
         rd(a[7:0], rv);
         check(64'(rv), 64'h0, "reset value");
      end
      wr(`OFS_ACC_PAIR0, 32'h0000_1234);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(`OFS_ACC_PAIR0, rv);
      check(64'(rv), 64'h0, "acc read-only");
      rd(8'h1C, rv);
      check(64'(rv), 64'h0, "unmapped");
      wr(`OFS_FREQ_WORD_PAIR0, 32'hC000_0001);
      wr(`OFS_FREQ_WORD_PAIR1, 32'h0000_1235);
      wr(`OFS_SYNC_SELECT, 32'h0000_0005);
      rd(`OFS_FREQ_WORD_PAIR0, rv);
      check(64'(rv), 64'hC000_0001, "freq readback");
      rd(`OFS_ACC_PAIR0, a0);
      rd(`OFS_ACC_PAIR0, rv);
      a0 = rv - a0;
      check(64'(a0), 64'h8000_0002, "acc0 step");
      rd(`OFS_ACC_PAIR1, a0);
      rd(`OFS_ACC_PAIR1, rv);
      a0 = rv - a0;
      check(64'(a0), 64'h246A, "acc1 step");
      // Sync clears both accumulators three edges after the pin rises
      @(posedge i_core_clk);
      i_sync_src[5] <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      rd(`OFS_ACC_PAIR0, rv);
      check(64'(rv), 64'h8000_0002, "acc0 after sync");
      rd(`OFS_ACC_PAIR1, rv);
      check(64'(rv), 64'h48D4, "acc1 after sync");
      wr(`OFS_FREQ_WORD_PAIR0, 32'h0);
      wr(`OFS_FREQ_WORD_PAIR1, 32'h0);
      i_sync_src[5] <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      i_sync_src[5] <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      pos = 0;
      // Fill the FIFO with the sink held off, then drain
      hold <= 1'b1;
      @(posedge i_core_clk);
      repeat (9) push(rnd());
      i_in_valid <= 1'b0;
      repeat (2) @(negedge i_core_clk);
      check(64'(o_in_ready), 64'h0, "fifo full");
      hold <= 1'b0;
      while (exp_q.size() > 0) @(posedge i_core_clk);
      @(negedge i_core_clk);
      check(64'(o_in_ready), 64'h1, "fifo empty");
      for (int m = 0; m < 16; m++) begin
         ctl.cmix       = modes[m % 8];
         ctl.gain       = m[3]; // Both gains with full-scale inputs
         ctl.full_mixer = 1'b0;
         setctl();
         burst(10);
      end
      for (int k = 0; k < 4; k++) begin
         ofs0           = 16'($random(seed)) & 16'hE000;
         ofs1           = 16'($random(seed)) & 16'hE000;
         ctl.cmix       = k[1] ? 4'h8 : 4'h0;
         ctl.gain       = k[0];
         ctl.full_mixer = 1'b1;
         wr(`OFS_PHASE_OFS, {ofs1, ofs0});
         setctl();
         burst(10);
      end
      test_done();
   end

   initial begin
      #500000;
      err_count++;
      test_done();
   end
endmodule
